// ==== src/adc_input_select_temp_offset.sv ====
// Converter positive-input selector and factory temperature offset registers
`timescale 1ns/1ps
module adc_input_select_temp_offset
  import amux_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Special-function register port
  input wire sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Sensor enable from the reference control register, production offset fuses
  input wire logic temp_sensor_enable,
  input wire logic [OFFSET_W-1:0] temp_offset_value,
  // Analog switch controls
  output amux_sel_s amux_sel,
  output logic cap_discharge,
  output logic sensor_hiz,
  output logic sensor_valid
);

  logic [CHAN_W-1:0] positive_input_select_r;
  logic [CHAN_W-1:0] positive_input_select_nxt;
  logic [OFFSET_W-1:0] offset_r;
  logic [OFFSET_W-1:0] offset_nxt;
  offset_load_e load_r;
  offset_load_e load_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic hit_r;
  logic hit_nxt;
  amux_sel_s amux_r;
  amux_sel_s amux_nxt;
  logic discharge_r;
  logic discharge_nxt;
  logic hiz_r;
  logic hiz_nxt;
  logic valid_r;
  logic valid_nxt;
  amux_sel_s dec_sel;
  logic chan_hit;
  logic temp_offset_high_byte_hit;
  logic temp_offset_low_byte_hit;

  assign chan_hit = (sfr_req.page == PAGE_CHAN) && (sfr_req.addr == ADDR_INPUT_CHANNEL_SELECT);
  assign temp_offset_high_byte_hit = (sfr_req.page == PAGE_TEMP_OFFSET_VALUE) && (sfr_req.addr == ADDR_TEMP_OFFSET_HIGH_BYTE);
  assign temp_offset_low_byte_hit = (sfr_req.page == PAGE_TEMP_OFFSET_VALUE) && (sfr_req.addr == ADDR_TEMP_OFFSET_LOW_BYTE);

  amux_decode u_decode (
    .code(positive_input_select_r),
    .sel(dec_sel)
  );

  // Register file
  always_comb
  begin
    positive_input_select_nxt = positive_input_select_r;
    rdata_nxt = rdata_r;
    hit_nxt = hit_r;
    if (sfr_req.wr && chan_hit)
    begin
      positive_input_select_nxt = sfr_req.wdata[CHAN_W-1:0];
    end
    if (sfr_req.rd)
    begin
      hit_nxt = chan_hit || temp_offset_high_byte_hit || temp_offset_low_byte_hit;
      rdata_nxt = RDATA_RESET;
      if (chan_hit)
      begin
        rdata_nxt = {3'h0, positive_input_select_r};
      end
      else if (temp_offset_high_byte_hit)
      begin
        rdata_nxt = offset_r[OFFSET_W-1:OFFSET_HIGH_LSB];
      end
      else if (temp_offset_low_byte_hit)
      begin
        rdata_nxt = {offset_r[OFFSET_HIGH_LSB-1:0], 6'h00};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      positive_input_select_r <= CHAN_RESET;
      rdata_r <= RDATA_RESET;
      hit_r <= 1'b0;
    end
    else
    begin
      positive_input_select_r <= positive_input_select_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
    end
  end

  // Fuse value is caught once after reset release; the fuses may not be settled
  // while reset is asserted, and writes never reach it
  always_comb
  begin
    offset_nxt = offset_r;
    load_nxt = load_r;
    case (load_r)
      LOAD_WAIT:
      begin
        offset_nxt = temp_offset_value;
        load_nxt = LOAD_DONE;
      end
      LOAD_DONE:
      begin
        load_nxt = LOAD_DONE;
      end
      default:
      begin
        load_nxt = LOAD_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      offset_r <= OFFSET_RESET;
      load_r <= LOAD_WAIT;
    end
    else
    begin
      offset_r <= offset_nxt;
      load_r <= load_nxt;
    end
  end

  // Switch drive is registered so the analog switches never see decode glitches
  always_comb
  begin
    amux_nxt = dec_sel;
    discharge_nxt = dec_sel.gnd_sel;
    hiz_nxt = !temp_sensor_enable;
    valid_nxt = temp_sensor_enable && dec_sel.temp_sel;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      amux_r <= '0;
      discharge_r <= 1'b0;
      hiz_r <= 1'b1;
      valid_r <= 1'b0;
    end
    else
    begin
      amux_r <= amux_nxt;
      discharge_r <= discharge_nxt;
      hiz_r <= hiz_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign sfr_hit = hit_r;
  assign amux_sel = amux_r;
  assign cap_discharge = discharge_r;
  assign sensor_hiz = hiz_r;
  assign sensor_valid = valid_r;

  // Checks
  property p_chan_write;
    @(posedge clk_sys) disable iff (rst)
    (sfr_req.wr && chan_hit) |=> (positive_input_select_r == $past(sfr_req.wdata[4:0]));
  endproperty
  a_chan_write: assert property (p_chan_write)
    else $error("channel code not stored on write");

  property p_chan_read;
    @(posedge clk_sys) disable iff (rst)
    (sfr_req.rd && chan_hit) |=> (rdata_r[7:5] == 3'h0) && hit_r
      && (rdata_r[4:0] == $past(positive_input_select_r));
  endproperty
  a_chan_read: assert property (p_chan_read)
    else $error("channel register read wrong");

  property p_port0;
    @(posedge clk_sys) disable iff (rst)
    (positive_input_select_r <= CODE_PORT0_LAST)
      |=> (amux_r.port0_sel == 8'(8'h01 << $past(positive_input_select_r)))
        && !amux_r.gnd_sel;
  endproperty
  a_port0: assert property (p_port0)
    else $error("port 0 pin not selected");

  property p_reserved;
    @(posedge clk_sys) disable iff (rst)
    (((positive_input_select_r > CODE_PORT0_LAST) && (positive_input_select_r < 5'h0C))
      || (positive_input_select_r == 5'h0F)
      || ((positive_input_select_r >= 5'h10) && (positive_input_select_r < CODE_TEMP)))
      |=> (amux_r == '0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code closed a switch");

  property p_temp_vbat;
    @(posedge clk_sys) disable iff (rst)
    ((positive_input_select_r == CODE_TEMP) |=> amux_r.temp_sel && !amux_r.vbat_sel)
      and ((positive_input_select_r == CODE_VBAT) |=> amux_r.vbat_sel && !amux_r.temp_sel);
  endproperty
  a_temp_vbat: assert property (p_temp_vbat)
    else $error("sensor or battery channel not routed");

  property p_ground;
    @(posedge clk_sys) disable iff (rst)
    (positive_input_select_r == CODE_GND) |=> amux_r.gnd_sel && cap_discharge
      && !amux_r.vdd_sel && !amux_r.temp_sel;
  endproperty
  a_ground: assert property (p_ground)
    else $error("ground code did not discharge");

  property p_reset_code;
    @(posedge clk_sys) disable iff (rst)
    (load_r == LOAD_WAIT) |-> (positive_input_select_r == CODE_GND) ##1 amux_r.gnd_sel;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("channel code not ground after reset");

  property p_sensor_hiz;
    @(posedge clk_sys) disable iff (rst)
    !temp_sensor_enable |=> sensor_hiz && !sensor_valid;
  endproperty
  a_sensor_hiz: assert property (p_sensor_hiz)
    else $error("disabled sensor not high impedance");

  property p_temp_offset_high_byte;
    @(posedge clk_sys) disable iff (rst)
    (sfr_req.rd && temp_offset_high_byte_hit) |=> (rdata_r == $past(offset_r[9:2]));
  endproperty
  a_temp_offset_high_byte: assert property (p_temp_offset_high_byte)
    else $error("offset high byte wrong");

  property p_temp_offset_low_byte;
    @(posedge clk_sys) disable iff (rst)
    (sfr_req.rd && temp_offset_low_byte_hit) |=> (rdata_r == {$past(offset_r[1:0]), 6'h00});
  endproperty
  a_temp_offset_low_byte: assert property (p_temp_offset_low_byte)
    else $error("offset low byte wrong");

  property p_offset_hold;
    @(posedge clk_sys) disable iff (rst)
    (load_r == LOAD_DONE) |=> $stable(offset_r) && (load_r == LOAD_DONE);
  endproperty
  a_offset_hold: assert property (p_offset_hold)
    else $error("offset changed after capture");

  c_temp: cover property (@(posedge clk_sys) disable iff (rst) sensor_valid);
  c_gnd_then_temp: cover property (@(posedge clk_sys) disable iff (rst)
    amux_r.gnd_sel ##1 amux_r.temp_sel);
  c_read_temp_offset_value: cover property (@(posedge clk_sys) disable iff (rst)
    sfr_req.rd && temp_offset_high_byte_hit ##2 sfr_req.rd && temp_offset_low_byte_hit);
  c_port1: cover property (@(posedge clk_sys) disable iff (rst) amux_r.port1_sel[2]);

endmodule : adc_input_select_temp_offset

// ==== include/amux_pkg.sv ====
// Constants and carrier types for the converter input selector block
package amux_pkg;

  // Register pages and addresses
  localparam logic [3:0] PAGE_CHAN = 4'h0;
  localparam logic [3:0] PAGE_TEMP_OFFSET_VALUE = 4'hF;
  localparam logic [7:0] ADDR_INPUT_CHANNEL_SELECT = 8'hBB;
  localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH_BYTE = 8'h86;
  localparam logic [7:0] ADDR_TEMP_OFFSET_LOW_BYTE = 8'h85;

  // Field layout
  localparam int CHAN_W = 5;
  localparam int OFFSET_W = 10;
  localparam int PORT0_PINS = 8;
  localparam int PORT1_PINS = 3;
  localparam int PORT1_FIRST_PIN = 4;
  localparam int OFFSET_HIGH_LSB = 2;
  localparam int OFFSET_LOW_POS = 6;

  // Reset values
  localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h1F;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 10'h000;

  // Channel codes
  localparam logic [CHAN_W-1:0] CODE_PORT0_LAST = 5'h07;
  localparam logic [CHAN_W-1:0] CODE_PORT1_FIRST = 5'h0C;
  localparam logic [CHAN_W-1:0] CODE_TEMP = 5'h1B;
  localparam logic [CHAN_W-1:0] CODE_VBAT = 5'h1C;
  localparam logic [CHAN_W-1:0] CODE_VREG = 5'h1D;
  localparam logic [CHAN_W-1:0] CODE_VDD = 5'h1E;
  localparam logic [CHAN_W-1:0] CODE_GND = 5'h1F;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic [PORT0_PINS-1:0] port0_sel;
    logic [PORT1_PINS-1:0] port1_sel;
    logic temp_sel;
    logic vbat_sel;
    logic vreg_sel;
    logic vdd_sel;
    logic gnd_sel;
  } amux_sel_s;

  typedef enum logic [0:0] {LOAD_WAIT, LOAD_DONE} offset_load_e;

endpackage : amux_pkg

// ==== src/amux_decode.sv ====
// Decoder from the channel code to one-hot analog switch enables
`timescale 1ns/1ps
module amux_decode
  import amux_pkg::*;
(
  // Channel code
  input wire logic [CHAN_W-1:0] code,
  // Switch enables
  output amux_sel_s sel
);

  logic [PORT0_PINS-1:0] p0;
  logic [PORT1_PINS-1:0] p1;

  genvar i;
  generate
    for (i = 0; i < PORT0_PINS; i++)
    begin : g_port0
      assign p0[i] = (code == CHAN_W'(i));
    end
    for (i = 0; i < PORT1_PINS; i++)
    begin : g_port1
      assign p1[i] = (code == CHAN_W'(CODE_PORT1_FIRST + CHAN_W'(i)));
    end
  endgenerate

  // Reserved codes leave every switch open
  always_comb
  begin
    sel = '0;
    sel.port0_sel = p0;
    sel.port1_sel = p1;
    sel.temp_sel = (code == CODE_TEMP);
    sel.vbat_sel = (code == CODE_VBAT);
    sel.vreg_sel = (code == CODE_VREG);
    sel.vdd_sel = (code == CODE_VDD);
    sel.gnd_sel = (code == CODE_GND);
  end

endmodule : amux_decode

// ==== tb/adc_input_select_temp_offset_tb_top.sv ====
// Self-checking bench for the converter input selector and offset registers
`timescale 1ns/1ps
module adc_input_select_temp_offset_tb_top;
  import amux_pkg::*;

  typedef struct packed {
    logic [4:0] code;
    logic [15:0] sel;
  } row_s;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sfr_req_s sfr_req = '0;
  logic temp_sensor_enable = 1'b0;
  logic [OFFSET_W-1:0] temp_offset_value = 10'h2D7;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  amux_sel_s amux_sel;
  logic cap_discharge;
  logic sensor_hiz;
  logic sensor_valid;
  int n_errors = 0;
  int tests_run = 0;

  // Switch bits: port 0 in 15:8, port 1 in 7:5, then sensor..ground
  row_s rows [15] = '{
    '{5'h00, 16'h0100}, '{5'h03, 16'h0800}, '{5'h07, 16'h8000}, '{5'h08, 16'h0000},
    '{5'h0B, 16'h0000}, '{5'h0C, 16'h0020}, '{5'h0D, 16'h0040}, '{5'h0E, 16'h0080},
    '{5'h0F, 16'h0000}, '{5'h10, 16'h0000}, '{5'h1A, 16'h0000}, '{5'h1B, 16'h0010},
    '{5'h1C, 16'h0008}, '{5'h1D, 16'h0004}, '{5'h1E, 16'h0002}
  };

  adc_input_select_temp_offset adc_input_select_temp_offset_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .temp_sensor_enable(temp_sensor_enable),
    .temp_offset_value(temp_offset_value),
    .amux_sel(amux_sel),
    .cap_discharge(cap_discharge),
    .sensor_hiz(sensor_hiz),
    .sensor_valid(sensor_valid)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One strobe cycle; read data is settled when this returns
  task automatic access(input logic [3:0] page, input logic [7:0] addr, input logic wr,
                        input logic [7:0] wdata);
    @(posedge clk_sys);
    #1;
    sfr_req = '{page, addr, wr, ~wr, wdata};
    @(posedge clk_sys);
    #1;
    sfr_req = '0;
  endtask : access

  task automatic rd(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] exp,
                    input logic exp_hit);
    access(page, addr, 1'b0, 8'h00);
    check({7'h00, sfr_hit, sfr_rdata}, {7'h00, exp_hit, exp});
  endtask : rd

  task automatic wait_edge();
    @(posedge clk_sys);
    #1;
  endtask : wait_edge

  task automatic check_outs(input logic [15:0] sel, input logic [2:0] flags);
    check(amux_sel, sel);
    check({13'h0000, cap_discharge, sensor_hiz, sensor_valid}, {13'h0000, flags});
  endtask : check_outs

  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    wait_edge();
    check_outs(16'h0001, 3'b110);
    rd(PAGE_CHAN, ADDR_INPUT_CHANNEL_SELECT, 8'h1F, 1'b1);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_HIGH_BYTE, 8'hB5, 1'b1);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_LOW_BYTE, 8'hC0, 1'b1);
    access(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_HIGH_BYTE, 1'b1, 8'h00);
    access(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_LOW_BYTE, 1'b1, 8'h3F);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_HIGH_BYTE, 8'hB5, 1'b1);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_LOW_BYTE, 8'hC0, 1'b1);
    // Right address on the wrong page must not answer
    rd(PAGE_CHAN, ADDR_TEMP_OFFSET_HIGH_BYTE, 8'h00, 1'b0);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_INPUT_CHANNEL_SELECT, 8'h00, 1'b0);
    $display("test reset and offset done");
    foreach (rows[i])
    begin
      access(PAGE_CHAN, ADDR_INPUT_CHANNEL_SELECT, 1'b1, {3'b111, rows[i].code});
      wait_edge();
      check(amux_sel, rows[i].sel);
      check({15'h0000, cap_discharge}, 16'h0000);
      rd(PAGE_CHAN, ADDR_INPUT_CHANNEL_SELECT, {3'b000, rows[i].code}, 1'b1);
    end
    $display("test channel table done");
    temp_sensor_enable = 1'b1;
    // Ground first, then the sensor, as software must do
    access(PAGE_CHAN, ADDR_INPUT_CHANNEL_SELECT, 1'b1, 8'h1F);
    wait_edge();
    check_outs(16'h0001, 3'b100);
    access(PAGE_CHAN, ADDR_INPUT_CHANNEL_SELECT, 1'b1, 8'h1B);
    wait_edge();
    check_outs(16'h0010, 3'b001);
    temp_sensor_enable = 1'b0;
    wait_edge();
    check_outs(16'h0010, 3'b010);
    $display("test sensor sequence done");
    // Fuses are taken once per reset, later changes stay unseen until the next one
    temp_offset_value = 10'h155;
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_HIGH_BYTE, 8'hB5, 1'b1);
    rst = 1'b1;
    wait_edge();
    check_outs(16'h0000, 3'b010);
    rst = 1'b0;
    wait_edge();
    check_outs(16'h0001, 3'b110);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_HIGH_BYTE, 8'h55, 1'b1);
    rd(PAGE_TEMP_OFFSET_VALUE, ADDR_TEMP_OFFSET_LOW_BYTE, 8'h40, 1'b1);
    rd(PAGE_CHAN, ADDR_INPUT_CHANNEL_SELECT, 8'h1F, 1'b1);
    $display("test second reset done");
    report_and_stop();
  end

endmodule : adc_input_select_temp_offset_tb_top
